// [include/flash_opt_pkg.sv]
// Shared constants and types for the flash option control block
package flash_opt_pkg;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFS_OPTKEY = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_OPTCTRL = 8'h14;
    localparam logic [31:0] OPTCTRL_RESET = 32'h0FFFAAED;
    // Writable option fields: bits 27:5 and 3:2
    localparam logic [31:0] OPTCTRL_FIELD_MASK = 32'h0FFFFFEC;
    localparam int LOCK_BIT = 0;
    localparam int GO_BIT = 1;
    localparam int UV_LSB = 2;
    localparam int WDG_BIT = 5;
    localparam int DEEP_SLEEP_BIT = 6;
    localparam int POWERDOWN_BIT = 7;
    localparam int RG_LSB = 8;
    localparam int WP_LSB = 16;
    localparam int WP_SECTORS = 12;
    localparam int FAULT_BIT = 4;
    localparam int BUSY_BIT = 16;
    localparam logic [7:0] RG_LEVEL0 = 8'hAA;
    localparam logic [7:0] RG_LEVEL2 = 8'hCC;
    localparam logic [1:0] UV_OFF = 2'h3;
    localparam int PROG_CYCLES_DEFAULT = 16;
    typedef enum logic [1:0] {GUARD_NONE, GUARD_PARTIAL, GUARD_FULL} readout_guard_t;
    typedef enum logic {KEY_WAIT_FIRST, KEY_WAIT_SECOND} key_state_t;
endpackage : flash_opt_pkg

// [hw/key_seq_detect.sv]
// Two-word unlock key sequence detector
`timescale 1ns/1ns
module key_seq_detect #(
    parameter logic [31:0] KEY_FIRST = 32'h13572468,
    parameter logic [31:0] KEY_SECOND = 32'h2468ACE0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic key_wr,
    input wire logic [31:0] key_data,
    output logic unlock
);
    import flash_opt_pkg::*;

    key_state_t state_reg;

    // Any wrong word restarts the sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= KEY_WAIT_FIRST;
        end else if (key_wr) begin
            case (state_reg)
                KEY_WAIT_FIRST: state_reg <= (key_data == KEY_FIRST) ? KEY_WAIT_SECOND : KEY_WAIT_FIRST;
                KEY_WAIT_SECOND: state_reg <= KEY_WAIT_FIRST;
                default: state_reg <= KEY_WAIT_FIRST;
            endcase
        end
    end

    assign unlock = key_wr && (state_reg == KEY_WAIT_SECOND) && (key_data == KEY_SECOND);
endmodule : key_seq_detect

// [hw/flash_option_control.sv]
// Flash option control register with APB access, unlock and option programming
// Functional notes
// - The option control register is only accessed while no flash operation runs; busy accesses are refused.
// - Reset loads the option control register with 0x0FFF AAED.
// - Bit 0 locks the register; software may set it and a correct key sequence clears it.
// - Bits 3:2 pick the undervoltage threshold, with code 11 disabling that reset.
// - Bit 5 picks hardware or software watchdog and bit 6 at 1 suppresses reset on deep sleep entry.
// - Bit 7 at 1 suppresses reset on powerdown entry, at 0 a reset occurs.
// - Bits 15:8 give readout guard: 0xAA none, 0xCC full, anything else partial.
// - Bits 27:16 are active-low sector write guards.
// - The status busy bit 16 reads 1 while any flash operation, option programming included, runs.
// - Erase or program on a guarded sector sets the guarded write fault, cleared by writing 1.
`timescale 1ns/1ns
module flash_option_control
    import flash_opt_pkg::*;
#(
    parameter logic [31:0] KEY_FIRST = 32'h13572468,  // Arbitrary value
    parameter logic [31:0] KEY_SECOND = 32'h2468ACE0, // Arbitrary value
    parameter int PROG_CYCLES = PROG_CYCLES_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [flash_opt_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic op_busy,
    input wire logic wr_attempt,
    input wire logic [3:0] wr_attempt_sector,
    output logic [1:0] undervoltage_threshold_sel,
    output logic undervoltage_reset_en,
    output logic watchdog_kind_sel,
    output logic no_reset_on_deep_sleep,
    output logic no_reset_on_powerdown,
    output flash_opt_pkg::readout_guard_t readout_guard_level,
    output logic [flash_opt_pkg::WP_SECTORS-1:0] sector_write_unguard,
    output logic flash_busy,
    output logic guarded_write_fault
);
    import flash_opt_pkg::*;

    localparam int CNT_W = $clog2(PROG_CYCLES + 1);

    if (PROG_CYCLES < 1) begin : g_bad_prog_cycles
        $error("PROG_CYCLES must be at least 1");
    end

    logic [31:0] opt_reg;
    logic [31:0] applied_reg;
    logic prog_active_reg;
    logic [CNT_W-1:0] prog_cnt_reg;
    logic busy_q_reg;
    logic fault_reg;
    logic unlock;
    logic access;
    logic setup;
    logic hit_key;
    logic hit_status;
    logic hit_opt;
    logic opt_refused;
    logic opt_wr_ok;
    logic launch;
    logic prog_done;
    logic busy_fell;
    logic fault_set;
    logic fault_clr;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign hit_key = (paddr == OFS_OPTKEY);
    assign hit_status = (paddr == OFS_STATUS);
    assign hit_opt = (paddr == OFS_OPTCTRL);
    assign flash_busy = op_busy || prog_active_reg;
    assign opt_refused = hit_opt && flash_busy;
    assign opt_wr_ok = access && pwrite && hit_opt && !flash_busy && !opt_reg[LOCK_BIT];
    assign launch = opt_wr_ok && pwdata[GO_BIT] && !opt_reg[GO_BIT];
    assign prog_done = prog_active_reg && (prog_cnt_reg == CNT_W'(PROG_CYCLES - 1));
    assign busy_fell = busy_q_reg && !flash_busy;
    assign pready = 1'b1;
    assign pslverr = access && (opt_refused || !(hit_key || hit_status || hit_opt));

    key_seq_detect #(
        .KEY_FIRST(KEY_FIRST),
        .KEY_SECOND(KEY_SECOND)
    ) u_key (
        .pclk(pclk),
        .presetn(presetn),
        .key_wr(access && pwrite && hit_key),
        .key_data(pwdata),
        .unlock(unlock)
    );

    // Lock and go bits; fields only move while unlocked and idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt_reg <= OPTCTRL_RESET;
        end else begin
            if (opt_wr_ok) begin
                opt_reg[31:2] <= pwdata[31:2] & OPTCTRL_FIELD_MASK[31:2];
                opt_reg[LOCK_BIT] <= pwdata[LOCK_BIT];
            end else if (unlock) begin
                opt_reg[LOCK_BIT] <= 1'b0;
            end
            if (launch) begin
                opt_reg[GO_BIT] <= 1'b1;
            end else if (opt_reg[GO_BIT] && busy_fell) begin
                opt_reg[GO_BIT] <= 1'b0;
            end
        end
    end

    // Option programming sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_active_reg <= 1'b0;
            prog_cnt_reg <= '0;
        end else if (launch) begin
            prog_active_reg <= 1'b1;
            prog_cnt_reg <= '0;
        end else if (prog_done) begin
            prog_active_reg <= 1'b0;
        end else if (prog_active_reg) begin
            prog_cnt_reg <= prog_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q_reg <= 1'b0;
        end else begin
            busy_q_reg <= flash_busy;
        end
    end

    // Options take effect only when programming completes, so edits in flight never glitch the chip
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            applied_reg <= OPTCTRL_RESET;
        end else if (prog_done) begin
            applied_reg <= opt_reg & OPTCTRL_FIELD_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            undervoltage_threshold_sel <= OPTCTRL_RESET[UV_LSB +: 2];
            undervoltage_reset_en <= (OPTCTRL_RESET[UV_LSB +: 2] != UV_OFF);
            watchdog_kind_sel <= OPTCTRL_RESET[WDG_BIT];
            no_reset_on_deep_sleep <= OPTCTRL_RESET[DEEP_SLEEP_BIT];
            no_reset_on_powerdown <= OPTCTRL_RESET[POWERDOWN_BIT];
            readout_guard_level <= GUARD_NONE;
            sector_write_unguard <= OPTCTRL_RESET[WP_LSB +: WP_SECTORS];
        end else begin
            undervoltage_threshold_sel <= applied_reg[UV_LSB +: 2];
            undervoltage_reset_en <= (applied_reg[UV_LSB +: 2] != UV_OFF);
            watchdog_kind_sel <= applied_reg[WDG_BIT];
            no_reset_on_deep_sleep <= applied_reg[DEEP_SLEEP_BIT];
            no_reset_on_powerdown <= applied_reg[POWERDOWN_BIT];
            if (applied_reg[RG_LSB +: 8] == RG_LEVEL0) begin
                readout_guard_level <= GUARD_NONE;
            end else if (applied_reg[RG_LSB +: 8] == RG_LEVEL2) begin
                readout_guard_level <= GUARD_FULL;
            end else begin
                readout_guard_level <= GUARD_PARTIAL;
            end
            sector_write_unguard <= applied_reg[WP_LSB +: WP_SECTORS];
        end
    end

    // Fault checks the applied guards; set wins over a same-cycle clear
    assign fault_set = wr_attempt && (wr_attempt_sector < 4'(WP_SECTORS))
        && !applied_reg[WP_LSB + int'(wr_attempt_sector)];
    assign fault_clr = access && pwrite && hit_status && pwdata[FAULT_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_reg <= 1'b0;
        end else if (fault_set) begin
            fault_reg <= 1'b1;
        end else if (fault_clr) begin
            fault_reg <= 1'b0;
        end
    end
    assign guarded_write_fault = fault_reg;

    // Read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup) begin
            prdata <= '0;
            if (!pwrite && hit_status) begin
                prdata[BUSY_BIT] <= flash_busy;
                prdata[FAULT_BIT] <= fault_reg;
            end else if (!pwrite && hit_opt && !flash_busy) begin
                prdata <= opt_reg;
            end
        end
    end

    sequence s_launch;
        access && pwrite && hit_opt && !flash_busy && !opt_reg[LOCK_BIT] && pwdata[GO_BIT] && !opt_reg[GO_BIT];
    endsequence

    sequence s_busy_then_idle;
        flash_busy ##[1:1000] !flash_busy;
    endsequence

    property p_busy_refused;
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && hit_opt && flash_busy && !unlock |=> $stable(opt_reg[31:2]);
    endproperty
    a_busy_refused: assert property (p_busy_refused) else $error("option write taken while busy");

    property p_unlock_clears;
        @(posedge pclk) disable iff (!presetn)
        unlock && !opt_wr_ok |=> !opt_reg[LOCK_BIT];
    endproperty
    a_unlock_clears: assert property (p_unlock_clears) else $error("lock not cleared by key");

    property p_launch_busy;
        @(posedge pclk) disable iff (!presetn)
        s_launch |=> s_busy_then_idle;
    endproperty
    a_launch_busy: assert property (p_launch_busy) else $error("busy missing after launch");

    property p_go_clears;
        @(posedge pclk) disable iff (!presetn)
        opt_reg[GO_BIT] && busy_q_reg && !flash_busy && !launch |=> !opt_reg[GO_BIT];
    endproperty
    a_go_clears: assert property (p_go_clears) else $error("go bit stuck after busy fell");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        opt_reg[FAULT_BIT] == 1'b0 && opt_reg[31:28] == 4'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved option bits set");

    property p_uv_disable;
        @(posedge pclk) disable iff (!presetn)
        prog_done |=> ##1 (undervoltage_reset_en == ($past(opt_reg[UV_LSB +: 2], 2) != UV_OFF));
    endproperty
    a_uv_disable: assert property (p_uv_disable) else $error("undervoltage enable wrong");

    property p_guard_full;
        @(posedge pclk) disable iff (!presetn)
        prog_done && opt_reg[RG_LSB +: 8] == RG_LEVEL2 |=> ##1 readout_guard_level == GUARD_FULL;
    endproperty
    a_guard_full: assert property (p_guard_full) else $error("readout guard not full");

    property p_fault_set;
        @(posedge pclk) disable iff (!presetn)
        wr_attempt && wr_attempt_sector < 4'(WP_SECTORS) && !sector_write_unguard[wr_attempt_sector]
            && !$past(prog_done) |=> guarded_write_fault;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("guarded write fault missed");

    property p_fault_clear;
        @(posedge pclk) disable iff (!presetn)
        fault_clr && !wr_attempt |=> !guarded_write_fault;
    endproperty
    a_fault_clear: assert property (p_fault_clear) else $error("fault not cleared by write");
endmodule : flash_option_control

// [verif/flash_option_control_tb.sv]
// Self-checking bench for the flash option control register block
`timescale 1ns/1ns
module flash_option_control_tb;
    import flash_opt_pkg::*;
    localparam int PROG_N = 2;
    localparam logic [31:0] K1 = 32'h13572468; // Arbitrary value
    localparam logic [31:0] K2 = 32'h2468ACE0; // Arbitrary value
    localparam logic [32:0] ALL = 33'h1FFFFFFFF;
    typedef struct packed {logic [32:0] exp; logic [32:0] mask;} note_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, op_busy, wr_attempt;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, v;
    logic [3:0] wr_attempt_sector;
    logic [1:0] undervoltage_threshold_sel;
    logic undervoltage_reset_en, watchdog_kind_sel, no_reset_on_deep_sleep, no_reset_on_powerdown;
    logic flash_busy, guarded_write_fault;
    readout_guard_t readout_guard_level;
    logic [WP_SECTORS-1:0] sector_write_unguard;
    note_t notes[$];
    note_t n;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 32'h644616bc;
    int k;

    flash_option_control #(.KEY_FIRST(K1), .KEY_SECOND(K2), .PROG_CYCLES(PROG_N)) dut (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_busy(op_busy), .wr_attempt(wr_attempt),
        .wr_attempt_sector(wr_attempt_sector), .undervoltage_threshold_sel(undervoltage_threshold_sel),
        .undervoltage_reset_en(undervoltage_reset_en), .watchdog_kind_sel(watchdog_kind_sel),
        .no_reset_on_deep_sleep(no_reset_on_deep_sleep), .no_reset_on_powerdown(no_reset_on_powerdown),
        .readout_guard_level(readout_guard_level), .sector_write_unguard(sector_write_unguard),
        .flash_busy(flash_busy), .guarded_write_fault(guarded_write_fault));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic final_report;
        $display("Checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Hung handshakes end here rather than stalling the run
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            final_report();
        end
    end

    // Taken at the completing edge, where pre-edge values are still visible
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            n = notes.pop_front();
            chk("apb", n.exp & n.mask, {pslverr, prdata} & n.mask);
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e,
                       input logic [32:0] m);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        notes.push_back({e, m});
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
        apb(1'b1, a, d, {err, 32'h0}, {1'b1, 32'h0});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic err, input logic [31:0] d);
        apb(1'b0, a, 32'h0, {err, d}, ALL);
    endtask : rd

    task automatic check_outputs(input logic [31:0] x);
        readout_guard_t g;
        g = (x[15:8] == RG_LEVEL0) ? GUARD_NONE : (x[15:8] == RG_LEVEL2) ? GUARD_FULL : GUARD_PARTIAL;
        @(negedge pclk);
        chk("uv_sel", 33'(x[3:2]), 33'(undervoltage_threshold_sel));
        chk("uv_en", 33'(x[3:2] != UV_OFF), 33'(undervoltage_reset_en));
        chk("wdg", 33'(x[5]), 33'(watchdog_kind_sel));
        chk("deep_sleep", 33'(x[6]), 33'(no_reset_on_deep_sleep));
        chk("powerdown", 33'(x[7]), 33'(no_reset_on_powerdown));
        chk("guard", 33'(g), 33'(readout_guard_level));
        chk("unguard", 33'(x[27:16]), 33'(sector_write_unguard));
    endtask : check_outputs

    task automatic attempt(input logic [3:0] s, input logic [31:0] st);
        @(posedge pclk);
        wr_attempt <= 1'b1;
        wr_attempt_sector <= s;
        @(posedge pclk);
        wr_attempt <= 1'b0;
        rd(OFS_STATUS, 1'b0, st);
    endtask : attempt

    initial begin
        {presetn, psel, penable, pwrite, op_busy, wr_attempt} = 6'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wr_attempt_sector = 4'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFS_OPTCTRL, 1'b0, OPTCTRL_RESET);
        check_outputs(OPTCTRL_RESET);
        rd(OFS_STATUS, 1'b0, 32'h0);
        wr(OFS_OPTCTRL, 32'h0, 1'b0);
        wr(OFS_OPTKEY, K1, 1'b0);
        wr(OFS_OPTKEY, 32'h0, 1'b0);
        wr(OFS_OPTKEY, K2, 1'b0);
        rd(OFS_OPTCTRL, 1'b0, OPTCTRL_RESET);
        wr(8'h10, 32'h1, 1'b1);
        rd(8'h10, 1'b1, 32'h0);
        wr(OFS_OPTKEY, K1, 1'b0);
        wr(OFS_OPTKEY, K2, 1'b0);
        rd(OFS_OPTKEY, 1'b0, 32'h0);
        rd(OFS_OPTCTRL, 1'b0, OPTCTRL_RESET & 32'hFFFFFFFE);
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            v[3:2] = i[1:0];
            v[1:0] = 2'b10;
            v[4] = 1'b1;
            v[31:28] = 4'hF;
            v[19] = 1'b0;
            v[20] = 1'b1;
            v[15:8] = (i == 0) ? RG_LEVEL0 : (i == 1) ? RG_LEVEL2 : (i == 3) ? 8'hAB : v[15:8];
            wr(OFS_OPTCTRL, v, 1'b0);
            if (i == 3) begin
                op_busy <= 1'b1;
                rd(OFS_STATUS, 1'b0, 32'h00010000);
                rd(OFS_OPTCTRL, 1'b1, 32'h0);
                wr(OFS_OPTCTRL, 32'h1, 1'b1);
                op_busy <= 1'b0;
                repeat (4) @(negedge pclk);
            end else begin
                k = 0;
                repeat (6) begin
                    @(negedge pclk);
                    if (flash_busy === 1'b1) k++;
                end
                chk("busy_len", 33'(PROG_N), 33'(k));
            end
            rd(OFS_OPTCTRL, 1'b0, v & OPTCTRL_FIELD_MASK);
            check_outputs(v);
        end
        attempt(4'd4, 32'h0);
        attempt(4'd13, 32'h0);
        attempt(4'd3, 32'h00000010);
        chk("fault", 33'h1, 33'(guarded_write_fault));
        wr(OFS_STATUS, 32'h00000010, 1'b0);
        rd(OFS_STATUS, 1'b0, 32'h0);
        // Go bit kept low so the relock write does not start another programming run
        wr(OFS_OPTCTRL, (v & 32'hFFFFFFFD) | 32'h1, 1'b0);
        wr(OFS_OPTCTRL, 32'h0, 1'b0);
        rd(OFS_OPTCTRL, 1'b0, (v & OPTCTRL_FIELD_MASK) | 32'h1);
        repeat (2) @(posedge pclk);
        final_report();
    end
endmodule : flash_option_control_tb
